//--- rtl/machine_cycle_bus_sequencer.sv
// Contract
// - A machine cycle is six states, S1 to S6, of two clocks each.
// - Each state splits into phase one and phase two, one clock each.
// - Two program byte fetches are issued in every normal machine cycle.
// - An unneeded fetched byte is dropped and the program counter holds.
// - The opcode enters the instruction register during state S1.
// - The second program fetch of a cycle spans states S4 to S6, its byte taken at the end of S6.
// - A one-cycle instruction completes at the end of state S6.
// - External data moves take two cycles; each of the two fetches one program byte.
// - Fetch timing is the same for internal and external program memory.
// - External program memory sees two read strobes per machine cycle.
// - A data move drops two program read strobes while the bus is busy.
// - A data bus cycle lasts ten clocks, two and a half times a four-clock program bus cycle.
// - Low address goes on the shared port, high on the upper port, latched by strobe.
// - Internal execution keeps the read strobe idle and emits no program address.
// - The address latch strobe pulses twice per cycle even when running internally.
// - One address latch strobe is dropped during an external data move.
// - All timing derives from the oscillator input, used as the clock.
`timescale 1ns/10ps
module machine_cycle_bus_sequencer (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ext_program_pin,
  input  wire logic        fetch_take,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_value,
  input  wire logic        dmove_request,
  input  wire logic        dmove_write,
  input  wire logic [15:0] dmove_address,
  input  wire logic [7:0]  dmove_wdata,
  input  wire logic [7:0]  rom_data,
  output logic      [15:0] rom_addr,
  output logic             rom_rd,
  output logic      [15:0] program_counter,
  output logic      [7:0]  opcode,
  output logic             opcode_strobe,
  output logic      [7:0]  fetch_byte,
  output logic             fetch_valid,
  output logic             exec_done,
  output logic      [7:0]  dmove_rdata,
  output logic             dmove_done,
  output logic             dmove_busy,
  output logic      [2:0]  machine_state,
  output logic             machine_phase,
  input  wire logic [7:0]  low_address_data_port_in,
  output logic      [7:0]  low_address_data_port_out,
  output logic             low_address_data_port_oe,
  output logic      [7:0]  high_address_port_out,
  output logic             high_address_port_oe,
  output logic             address_latch_strobe,
  output logic             program_read_strobe_n,
  output logic             data_read_strobe_n,
  output logic             data_write_strobe_n
);

  seq_if sq ();

  // ----------------------------------------------------------------
  // Timer and strobe generators
  // ----------------------------------------------------------------
  cycle_timer u_timer (
    .clk  (clk),
    .srst (srst),
    .tim  (sq.timer_mp)
  );

  strobe_gen u_strobe (
    .clk  (clk),
    .srst (srst),
    .sq   (sq.strobe_mp)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       ext_meta;
  logic       ext_sync;
  logic [7:0] port_meta;
  logic [7:0] port_sync;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_meta  <= 1'h0;
      ext_sync  <= 1'h0;
      port_meta <= seq_pkg::BYTE_RESET;
      port_sync <= seq_pkg::BYTE_RESET;
    end else begin
      ext_meta  <= ext_program_pin;
      ext_sync  <= ext_meta;
      port_meta <= low_address_data_port_in;
      port_sync <= port_meta;
    end
  end

  // ----------------------------------------------------------------
  // Slot decode
  // ----------------------------------------------------------------
  seq_pkg::seq_t seq;
  logic          hi_slot;
  logic [1:0]    rel;
  logic          data_slot;
  logic          prog_live;
  logic          cap_edge;
  logic          cycle_start;
  logic          cycle_end;

  always_comb begin
    hi_slot     = seq_pkg::slot_b(sq.state);
    rel         = seq_pkg::slot_rel(sq.state);
    data_slot   = (seq == seq_pkg::SEQ_DMOVE_FIRST && hi_slot)
                  || (seq == seq_pkg::SEQ_DMOVE_SECOND && !hi_slot);
    prog_live   = !data_slot;
    cap_edge    = (rel == seq_pkg::REL_LAST) && (sq.phase == seq_pkg::PHASE_2);
    cycle_start = (sq.state == seq_pkg::STATE_S1) && (sq.phase == seq_pkg::PHASE_1);
    cycle_end   = (sq.state == seq_pkg::STATE_S6) && (sq.phase == seq_pkg::PHASE_2);
  end

  // ----------------------------------------------------------------
  // Data move sequence
  // ----------------------------------------------------------------
  seq_pkg::seq_t next_seq;
  logic          mv_write;
  logic [15:0]   mv_addr;
  logic [7:0]    mv_wdata;
  logic          next_mv_write;
  logic [15:0]   next_mv_addr;
  logic [7:0]    next_mv_wdata;

  always_comb begin
    next_seq      = seq;
    next_mv_write = mv_write;
    next_mv_addr  = mv_addr;
    next_mv_wdata = mv_wdata;
    case (seq)
      seq_pkg::SEQ_NORMAL: begin
        if (cycle_start && dmove_request) begin
          next_seq      = seq_pkg::SEQ_DMOVE_FIRST;
          next_mv_write = dmove_write;
          next_mv_addr  = dmove_address;
          next_mv_wdata = dmove_wdata;
        end
      end
      seq_pkg::SEQ_DMOVE_FIRST: begin
        if (cycle_end) begin
          next_seq = seq_pkg::SEQ_DMOVE_SECOND;
        end
      end
      seq_pkg::SEQ_DMOVE_SECOND: begin
        if (cycle_end) begin
          next_seq = seq_pkg::SEQ_NORMAL;
        end
      end
      default: begin
        next_seq = seq_pkg::SEQ_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq      <= seq_pkg::SEQ_NORMAL;
      mv_write <= 1'h0;
      mv_addr  <= seq_pkg::PC_RESET;
      mv_wdata <= seq_pkg::BYTE_RESET;
    end else begin
      seq      <= next_seq;
      mv_write <= next_mv_write;
      mv_addr  <= next_mv_addr;
      mv_wdata <= next_mv_wdata;
    end
  end

  assign sq.ext_prog    = ext_sync;
  assign sq.dmove_first  = (seq == seq_pkg::SEQ_DMOVE_FIRST);
  assign sq.dmove_second = (seq == seq_pkg::SEQ_DMOVE_SECOND);
  assign sq.dmove_write  = mv_write;

  // ----------------------------------------------------------------
  // Fetch, program counter and instruction register
  // ----------------------------------------------------------------
  logic [15:0] pc;
  logic [7:0]  fbyte;
  logic [7:0]  ir;
  logic [7:0]  rdata;
  logic        fvalid;
  logic        op_stb;
  logic        done;
  logic        mv_done;
  logic [15:0] next_pc;
  logic [7:0]  next_fbyte;
  logic [7:0]  next_ir;
  logic [7:0]  next_rdata;
  logic        next_fvalid;
  logic        next_op_stb;
  logic        next_done;
  logic        next_mv_done;

  always_comb begin
    next_pc      = pc;
    next_fbyte   = fbyte;
    next_ir      = ir;
    next_rdata   = rdata;
    next_fvalid  = 1'h0;
    next_op_stb  = 1'h0;
    next_done    = 1'h0;
    next_mv_done = 1'h0;
    if (cap_edge && prog_live) begin
      next_fbyte  = ext_sync ? port_sync : rom_data;
      next_fvalid = 1'h1;
      if (fetch_take) begin
        next_pc = pc + 16'h0001;
      end
    end
    if (pc_load) begin
      next_pc = pc_load_value;
    end
    if (sq.state == seq_pkg::STATE_S1 && sq.phase == seq_pkg::PHASE_2
        && seq != seq_pkg::SEQ_DMOVE_SECOND) begin
      next_ir     = fbyte;
      next_op_stb = 1'h1;
    end
    if (cycle_end && seq != seq_pkg::SEQ_DMOVE_FIRST) begin
      next_done = 1'h1;
    end
    if (seq == seq_pkg::SEQ_DMOVE_SECOND && sq.state == seq_pkg::STATE_S3
        && sq.phase == seq_pkg::PHASE_2) begin
      next_mv_done = 1'h1;
      if (!mv_write) begin
        next_rdata = port_sync;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc      <= seq_pkg::PC_RESET;
      fbyte   <= seq_pkg::BYTE_RESET;
      ir      <= seq_pkg::BYTE_RESET;
      rdata   <= seq_pkg::BYTE_RESET;
      fvalid  <= 1'h0;
      op_stb  <= 1'h0;
      done    <= 1'h0;
      mv_done <= 1'h0;
    end else begin
      pc      <= next_pc;
      fbyte   <= next_fbyte;
      ir      <= next_ir;
      rdata   <= next_rdata;
      fvalid  <= next_fvalid;
      op_stb  <= next_op_stb;
      done    <= next_done;
      mv_done <= next_mv_done;
    end
  end

  // ----------------------------------------------------------------
  // Address and data port drive
  // ----------------------------------------------------------------
  logic [7:0] lo_out;
  logic       lo_oe;
  logic [7:0] hi_out;
  logic       hi_oe;
  logic [7:0] next_lo_out;
  logic       next_lo_oe;
  logic [7:0] next_hi_out;
  logic       next_hi_oe;

  always_comb begin
    next_lo_out = lo_out;
    next_lo_oe  = 1'h0;
    next_hi_out = hi_out;
    next_hi_oe  = 1'h0;
    if (data_slot) begin
      next_hi_out = mv_addr[15:8];
      next_hi_oe  = 1'h1;
      if (seq == seq_pkg::SEQ_DMOVE_FIRST && rel == seq_pkg::REL_ADDR) begin
        next_lo_out = mv_addr[7:0];
        next_lo_oe  = 1'h1;
      end else if (mv_write) begin
        next_lo_out = mv_wdata;
        next_lo_oe  = 1'h1;
      end
    end else if (ext_sync) begin
      next_hi_out = pc[15:8];
      next_hi_oe  = 1'h1;
      if (rel == seq_pkg::REL_ADDR) begin
        next_lo_out = pc[7:0];
        next_lo_oe  = 1'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lo_out <= seq_pkg::BYTE_RESET;
      lo_oe  <= 1'h0;
      hi_out <= seq_pkg::BYTE_RESET;
      hi_oe  <= 1'h0;
    end else begin
      lo_out <= next_lo_out;
      lo_oe  <= next_lo_oe;
      hi_out <= next_hi_out;
      hi_oe  <= next_hi_oe;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rom_addr                  = pc;
  assign rom_rd                    = cap_edge && prog_live && !ext_sync;
  assign program_counter           = pc;
  assign opcode                    = ir;
  assign opcode_strobe             = op_stb;
  assign fetch_byte                = fbyte;
  assign fetch_valid               = fvalid;
  assign exec_done                 = done;
  assign dmove_rdata               = rdata;
  assign dmove_done                = mv_done;
  assign dmove_busy                = (seq != seq_pkg::SEQ_NORMAL);
  assign machine_state             = sq.state;
  assign machine_phase             = sq.phase;
  assign low_address_data_port_out = lo_out;
  assign low_address_data_port_oe  = lo_oe;
  assign high_address_port_out     = hi_out;
  assign high_address_port_oe      = hi_oe;
  assign address_latch_strobe      = sq.ale;
  assign program_read_strobe_n     = sq.prog_rd_n;
  assign data_read_strobe_n        = sq.data_rd_n;
  assign data_write_strobe_n       = sq.data_wr_n;

endmodule

//--- rtl/seq_pkg.sv
package seq_pkg;

  // ----------------------------------------------------------------
  // Machine cycle geometry
  // ----------------------------------------------------------------
  localparam int         STATE_W    = 3;
  localparam logic [2:0] STATE_S1   = 3'h0;
  localparam logic [2:0] STATE_S3   = 3'h2;
  localparam logic [2:0] STATE_S4   = 3'h3;
  localparam logic [2:0] STATE_S6   = 3'h5;
  localparam logic [2:0] SLOT_LEN   = 3'h3;
  localparam logic [1:0] REL_ADDR   = 2'h0;
  localparam logic [1:0] REL_LAST   = 2'h2;
  localparam logic       PHASE_1    = 1'h0;
  localparam logic       PHASE_2    = 1'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Bus sequence of the current machine cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_NORMAL,
    SEQ_DMOVE_FIRST,
    SEQ_DMOVE_SECOND
  } seq_t;

  // Second fetch slot covers S4..S6
  function automatic logic slot_b(input logic [2:0] state);
    slot_b = (state >= STATE_S4);
  endfunction

  // Position of a state inside its fetch slot
  function automatic logic [1:0] slot_rel(input logic [2:0] state);
    logic [2:0] rel;
    rel = slot_b(state) ? (state - SLOT_LEN) : state;
    slot_rel = rel[1:0];
  endfunction

endpackage

//--- rtl/seq_if.sv
`timescale 1ns/10ps
interface seq_if;
  logic [2:0] state;
  logic       phase;
  logic       ext_prog;
  logic       dmove_first;
  logic       dmove_second;
  logic       dmove_write;
  logic       ale;
  logic       prog_rd_n;
  logic       data_rd_n;
  logic       data_wr_n;

  modport timer_mp (output state, output phase);
  modport strobe_mp (input state, input phase, input ext_prog, input dmove_first,
                     input dmove_second, input dmove_write, output ale, output prog_rd_n,
                     output data_rd_n, output data_wr_n);
  modport core_mp (input state, input phase, input ale, input prog_rd_n, input data_rd_n,
                   input data_wr_n, output ext_prog, output dmove_first, output dmove_second,
                   output dmove_write);
endinterface

//--- rtl/cycle_timer.sv
`timescale 1ns/10ps
module cycle_timer (
  input  wire logic clk,
  input  wire logic srst,
  seq_if.timer_mp   tim
);

  logic [2:0] state;
  logic       phase;
  logic [2:0] next_state;
  logic       next_phase;

  // ----------------------------------------------------------------
  // Six states of two phases each
  // ----------------------------------------------------------------
  always_comb begin
    next_phase = ~phase;
    next_state = state;
    if (phase == seq_pkg::PHASE_2) begin
      if (state == seq_pkg::STATE_S6) begin
        next_state = seq_pkg::STATE_S1;
      end else begin
        next_state = state + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= seq_pkg::STATE_S1;
      phase <= seq_pkg::PHASE_1;
    end else begin
      state <= next_state;
      phase <= next_phase;
    end
  end

  assign tim.state = state;
  assign tim.phase = phase;

endmodule

//--- rtl/strobe_gen.sv
`timescale 1ns/10ps
module strobe_gen (
  input  wire logic clk,
  input  wire logic srst,
  seq_if.strobe_mp  sq
);

  logic ale;
  logic prog_rd_n;
  logic data_rd_n;
  logic data_wr_n;
  logic next_ale;
  logic next_prog_rd_n;
  logic next_data_rd_n;
  logic next_data_wr_n;

  // ----------------------------------------------------------------
  // Strobe decode per fetch slot
  // ----------------------------------------------------------------
  always_comb begin
    logic       hi;
    logic [1:0] rel;
    logic       data;
    logic       data_strobe;
    hi          = seq_pkg::slot_b(sq.state);
    rel         = seq_pkg::slot_rel(sq.state);
    data        = (sq.dmove_first && hi) || (sq.dmove_second && !hi);
    data_strobe = data && !(sq.dmove_first && rel == seq_pkg::REL_ADDR);
    next_ale       = (rel == seq_pkg::REL_ADDR) && !(sq.dmove_second && !hi);
    next_prog_rd_n = !(sq.ext_prog && !data && rel != seq_pkg::REL_ADDR);
    next_data_rd_n = !(data_strobe && !sq.dmove_write);
    next_data_wr_n = !(data_strobe && sq.dmove_write);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ale       <= 1'h0;
      prog_rd_n <= 1'h1;
      data_rd_n <= 1'h1;
      data_wr_n <= 1'h1;
    end else begin
      ale       <= next_ale;
      prog_rd_n <= next_prog_rd_n;
      data_rd_n <= next_data_rd_n;
      data_wr_n <= next_data_wr_n;
    end
  end

  assign sq.ale       = ale;
  assign sq.prog_rd_n = prog_rd_n;
  assign sq.data_rd_n = data_rd_n;
  assign sq.data_wr_n = data_wr_n;

endmodule

//--- test/ext_memory_model.sv
`timescale 1ns/10ps
module ext_memory_model (
  input  wire logic       clk,
  input  wire logic [7:0] port_level,
  input  wire logic [7:0] high_addr,
  input  wire logic       ale,
  input  wire logic       prog_rd_n,
  input  wire logic       data_rd_n,
  input  wire logic       data_wr_n,
  output logic      [7:0] drive
);
  logic [7:0]  lo_latch;
  logic [7:0]  hi_latch;
  logic [7:0]  last = 8'h00;
  logic [15:0] waddr;
  logic [7:0]  wdat;

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    mem_byte = a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  always @(posedge clk) begin
    last <= port_level;
    if (ale) begin
      lo_latch <= port_level;
      hi_latch <= high_addr;
    end
    if (!data_wr_n) begin
      waddr <= {hi_latch, lo_latch};
      wdat  <= port_level;
    end
  end

  // Answer under a read strobe, else a pattern that moves every clock
  assign drive = (!prog_rd_n || !data_rd_n) ? mem_byte({hi_latch, lo_latch}) : ~last;
endmodule

//--- test/machine_cycle_bus_sequencer_assertions.sv
`timescale 1ns/10ps
module seq_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [2:0] machine_state,
  input wire logic       machine_phase,
  input wire logic       address_latch_strobe,
  input wire logic       program_read_strobe_n,
  input wire logic       data_read_strobe_n,
  input wire logic       data_write_strobe_n,
  input wire logic       low_address_data_port_oe,
  input wire logic       exec_done,
  input wire logic       fetch_valid
);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Data strobe length
  // ----------------------------------------------------------------
  always_comb begin
    next_low_cnt = (!data_read_strobe_n || !data_write_strobe_n) ? low_cnt + 8'h01 : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (srst) low_cnt <= 8'h00;
    else low_cnt <= next_low_cnt;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  phase_toggle_a: assert property (!$past(srst) |-> machine_phase != $past(machine_phase))
    else $error("phase did not alternate");
  state_hold_a: assert property (!$past(srst) && !$past(machine_phase) |-> $stable(machine_state))
    else $error("state moved inside a state");
  state_step_a: assert property (!$past(srst) && $past(machine_phase) |-> machine_state ==
      (($past(machine_state) == seq_pkg::STATE_S6) ? seq_pkg::STATE_S1 : $past(machine_state) + 3'h1))
    else $error("state sequence broken");
  ale_width_a: assert property ($rose(address_latch_strobe) |->
      address_latch_strobe [*2] ##1 !address_latch_strobe)
    else $error("latch strobe width wrong");
  ale_spacing_a: assert property ($rose(address_latch_strobe) |=> !$rose(address_latch_strobe) [*5])
    else $error("latch strobes too close");
  ale_place_a: assert property ($rose(address_latch_strobe) |-> machine_phase &&
      (machine_state == seq_pkg::STATE_S1 || machine_state == seq_pkg::STATE_S4))
    else $error("latch strobe at wrong state");
  prog_width_a: assert property ($fell(program_read_strobe_n) |->
      !program_read_strobe_n [*4] ##1 program_read_strobe_n)
    else $error("program strobe width wrong");
  prog_bus_a: assert property (!program_read_strobe_n |->
      !low_address_data_port_oe && !address_latch_strobe)
    else $error("port driven under program strobe");
  data_len_a: assert property ($rose(data_read_strobe_n & data_write_strobe_n) |->
      low_cnt == 8'h0A)
    else $error("data strobe length wrong");
  done_place_a: assert property (exec_done |-> machine_state == seq_pkg::STATE_S1 &&
      !machine_phase)
    else $error("completion at wrong state");
  fetch_gap_a: assert property (fetch_valid |=> !fetch_valid [*5])
    else $error("fetches too close");
endmodule

bind machine_cycle_bus_sequencer seq_checker chk (.clk, .srst, .machine_state, .machine_phase,
  .address_latch_strobe, .program_read_strobe_n, .data_read_strobe_n, .data_write_strobe_n,
  .low_address_data_port_oe, .exec_done, .fetch_valid);

//--- test/machine_cycle_bus_sequencer_tb.sv
`timescale 1ns/10ps
module machine_cycle_bus_sequencer_tb;
  logic        clk = 1'b0, srst = 1'b1, ext = 1'b0, take = 1'b0, pc_load = 1'b0;
  logic        req = 1'b0, wr = 1'b0;
  logic [15:0] pc_val = 16'h0000, pc, rom_addr, pc0;
  logic [7:0]  fetch_byte, dmove_rdata, lo_out, hi_out, lo_in, drv, opcode, lastb;
  logic [2:0]  machine_state;
  logic        fetch_valid, exec_done, dmove_done, dmove_busy, machine_phase, lo_oe;
  logic        opcode_strobe;
  logic        address_latch_strobe, program_read_strobe_n, data_read_strobe_n;
  logic        data_write_strobe_n;
  logic [15:0] n_ale, n_ps, n_dl, n_fv, n_oe, n_done, n_md, failures = 16'h0000, checks = 16'h0000;

  machine_cycle_bus_sequencer uut (.clk, .srst, .ext_program_pin(ext), .fetch_take(take),
    .pc_load, .pc_load_value(pc_val), .dmove_request(req), .dmove_write(wr),
    .dmove_address(16'hBE42), .dmove_wdata(8'h5A), .rom_data(rom_addr[7:0] ^ 8'h3C), .rom_addr,
    .rom_rd(), .program_counter(pc), .opcode, .opcode_strobe, .fetch_byte, .fetch_valid,
    .exec_done, .dmove_rdata, .dmove_done, .dmove_busy, .machine_state, .machine_phase,
    .low_address_data_port_in(lo_in), .low_address_data_port_out(lo_out),
    .low_address_data_port_oe(lo_oe), .high_address_port_out(hi_out), .high_address_port_oe(),
    .address_latch_strobe, .program_read_strobe_n, .data_read_strobe_n, .data_write_strobe_n);

  ext_memory_model mdl (.clk, .port_level(lo_in), .high_addr(hi_out), .ale(address_latch_strobe),
    .prog_rd_n(program_read_strobe_n), .data_rd_n(data_read_strobe_n),
    .data_wr_n(data_write_strobe_n), .drive(drv));

  assign lo_in = lo_oe ? lo_out : drv;

  initial forever #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task cmp(input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: expected %h got %h", $time, exp, got);
    end
  endtask

  task conclude;
    if (failures == 16'h0000 && checks > 16'h0000) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Step to S1 and optionally request a data move there
  task align(input logic move);
    int i;
    for (i = 0; i < 20 && !(machine_state === 3'h5 && machine_phase === 1'b1); i++) @(negedge clk);
    if (i == 20) begin
      failures++;
      conclude;
    end
    @(posedge clk) req <= move;
    @(posedge clk) req <= 1'b0;
    pc0 = pc;
  endtask

  // Two machine cycles of pin activity
  task run(input logic chk);
    logic [15:0] a;
    logic        pa, pp;
    pa = 1'b0;
    pp = 1'b1;
    lastb = fetch_byte;
    {n_ale, n_ps, n_dl, n_fv, n_oe, n_done, n_md} = '0;
    repeat (24) begin
      @(negedge clk);
      if (address_latch_strobe === 1'b1 && !pa) n_ale++;
      if (program_read_strobe_n === 1'b0 && pp) n_ps++;
      if (data_read_strobe_n === 1'b0 || data_write_strobe_n === 1'b0) n_dl++;
      if (lo_oe === 1'b1) n_oe++;
      if (exec_done === 1'b1) n_done++;
      if (dmove_done === 1'b1) begin
        n_md++;
        cmp(16'h0001, {15'h0000, dmove_busy});
      end
      if (chk && opcode_strobe === 1'b1) cmp({8'h00, lastb}, {8'h00, opcode});
      if (fetch_valid === 1'b1) begin
        n_fv++;
        a = pc - {15'h0000, take};
        if (chk) cmp({8'h00, ext ? mdl.mem_byte(a) : a[7:0] ^ 8'h3C}, {8'h00, fetch_byte});
        lastb = fetch_byte;
      end
      pa = address_latch_strobe;
      pp = program_read_strobe_n;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_internal;
    @(posedge clk) take <= 1'b0;
    align(1'b0);
    run(1'b1);
    cmp(16'h0004, n_ale);
    cmp(16'h0000, n_ps);
    cmp(16'h0000, n_oe);
    cmp(16'h0004, n_fv);
    cmp(16'h0002, n_done);
    cmp(pc0, pc);
    @(posedge clk) take <= 1'b1;
    align(1'b0);
    run(1'b1);
    cmp(pc0 + 16'h0004, pc);
  endtask

  task t_external;
    @(posedge clk) begin
      pc_load <= 1'b1;
      pc_val  <= 16'h12F0;
    end
    @(posedge clk) begin
      pc_load <= 1'b0;
      ext     <= 1'b1;
    end
    align(1'b0);
    run(1'b0);
    align(1'b0);
    run(1'b1);
    cmp(16'h0004, n_ps);
    cmp(16'h0004, n_ale);
    cmp(16'h0004, n_fv);
    cmp(16'h0002, n_done);
    cmp(pc0 + 16'h0004, pc);
  endtask

  task t_move;
    for (int w = 0; w < 2; w++) begin
      @(posedge clk) wr <= w[0];
      align(1'b1);
      run(1'b0);
      cmp(16'h0003, n_ale);
      cmp(16'h0002, n_ps);
      cmp(16'h000A, n_dl);
      cmp(16'h0001, n_md);
      cmp(16'h0001, n_done);
      if (w == 1) begin
        cmp(16'hBE42, mdl.waddr);
        cmp(16'h005A, {8'h00, mdl.wdat});
      end else begin
        cmp({8'h00, mdl.mem_byte(16'hBE42)}, {8'h00, dmove_rdata});
      end
      cmp(16'h0000, {15'h0000, dmove_busy});
    end
  endtask

  task t_reset;
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    @(negedge clk);
    cmp(16'h0000, pc);
    align(1'b0);
    run(1'b0);
    cmp(16'h0002, n_done);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_internal;
    t_external;
    t_move;
    t_reset;
    conclude;
  end
endmodule
